// ---- rtl/afr_redirect.sv ----
/*
 Alternate function pin redirect: three control SFRs and the muxing between
 peripherals and port pins. Assumes the CPU provides an SFR bus with one-cycle
 write and combinational read, and that the port block applies the returned
 out/oe per pin together with its own latch and mode bits.
*/
`timescale 1ns/1ps
module afr_redirect (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // SFR bus (page ignored: registers are on every page)
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Clock source state
    input wire afr_pkg::afr_osc_mode_t osc_mode,
    // Pin levels (synchronised) and peripheral outputs
    input wire afr_pkg::afr_ports_t pin_in,
    input wire logic uart0_tx,
    input wire logic uart1_tx,
    input wire logic spi_mosi_out,
    input wire logic spi_mosi_oe,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe,
    input wire logic spi_sck_out,
    input wire logic spi_sck_oe,
    input wire logic t2_clk_out,
    input wire logic t2_clk_oe,
    input wire logic t3_clk_out,
    input wire logic t3_clk_oe,
    input wire logic [5:0] counter_array_out,
    input wire logic [5:0] counter_array_oe,
    // Peripheral inputs
    output logic uart0_rx,
    output logic uart1_rx,
    output logic spi_ss_in,
    output logic spi_mosi_in,
    output logic spi_miso_in,
    output logic spi_sck_in,
    output logic t2_in,
    output logic t2_ext_in,
    output logic t3_in,
    output logic t3_ext_in,
    output logic counter_array_ext_clock,
    output logic [5:0] counter_array_in,
    output logic [7:0] keypad_in,
    output logic ext_irq2_in,
    output logic ext_irq3_in,
    // Alternate function overrides to the port block
    output afr_pkg::afr_ports_t alt_out,
    output afr_pkg::afr_ports_t alt_oe,
    output logic clk_pin_crystal,
    output logic clk_pin_fast_drive
);
    import afr_pkg::*;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic wr0;
    logic wr1;
    logic wr2;

    // Address decode, page independent
    assign wr0 = sfr_wr && (sfr_addr == AFR_ADDR_CTRL0);
    assign wr1 = sfr_wr && (sfr_addr == AFR_ADDR_CTRL1);
    assign wr2 = sfr_wr && (sfr_addr == AFR_ADDR_CTRL2);
    assign sfr_hit = (sfr_addr == AFR_ADDR_CTRL0) || (sfr_addr == AFR_ADDR_CTRL1)
        || (sfr_addr == AFR_ADDR_CTRL2);

    // Register store; zero reset leaves every function at home
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl0 <= AFR_RESET_VAL;
            ctrl1 <= AFR_RESET_VAL;
            ctrl2 <= AFR_RESET_VAL;
        end else begin
            if (wr0) ctrl0 <= sfr_wdata;
            if (wr1) ctrl1 <= sfr_wdata;
            if (wr2) ctrl2 <= sfr_wdata;
        end
    end

    // Read mux; unmapped addresses return zero
    assign sfr_rdata = (sfr_addr == AFR_ADDR_CTRL0) ? ctrl0 :
        (sfr_addr == AFR_ADDR_CTRL1) ? ctrl1 :
        (sfr_addr == AFR_ADDR_CTRL2) ? ctrl2 : 8'h00;

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    afr_clk_fn_t clk_pin_function_sel;
    afr_p4_fn_t port4_sel;
    afr_irq_src_t irq3_sel;
    afr_irq_src_t irq2_sel;
    logic [1:0] keypad_port_sel;
    logic spi_relocate;
    logic serial1_relocate;
    logic timer2_relocate;
    logic counter_array_relocate;
    logic internal_osc;
    logic clk_out_gen;
    logic clk_pin_active;

    assign clk_pin_function_sel = afr_clk_fn_t'(ctrl0[AFR_CLK_SEL_HI:AFR_CLK_SEL_LO]);
    assign port4_sel = afr_p4_fn_t'(ctrl0[AFR_P4_SEL_HI:AFR_P4_SEL_LO]);
    assign keypad_port_sel = ctrl1[AFR_KEY_SEL_HI:AFR_KEY_SEL_LO];
    assign spi_relocate = ctrl1[AFR_SPI_RELOC];
    assign serial1_relocate = ctrl1[AFR_UART1_RELOC];
    assign timer2_relocate = ctrl1[AFR_T2_RELOC];
    assign counter_array_relocate = ctrl1[AFR_CNT_ARRAY_RELOC];
    assign irq3_sel = afr_irq_src_t'(ctrl2[AFR_IRQ3_SEL_HI:AFR_IRQ3_SEL_LO]);
    assign irq2_sel = afr_irq_src_t'(ctrl2[AFR_IRQ2_SEL_HI:AFR_IRQ2_SEL_LO]);

    // ------------------------------------------------------------
    // Clock-capable pin 6.0
    // ------------------------------------------------------------
    // Field only counts with an internal RC oscillator; else pin is oscillator's
    assign internal_osc = (osc_mode == AFR_OSC_INTERNAL);
    assign clk_pin_crystal = !internal_osc;
    assign clk_pin_active = internal_osc && (clk_pin_function_sel != AFR_CLK_GPIO);
    // Drive only; push-pull or open-drain stays with the port mode bit
    assign clk_pin_fast_drive = ctrl0[AFR_FAST_DRIVE];

    afr_clk_div u_clk_div (
        .clk(clk),
        .nrst(nrst),
        .fn(clk_pin_function_sel),
        .clk_out(clk_out_gen)
    );

    // ------------------------------------------------------------
    // Peripheral inputs from the active pin
    // ------------------------------------------------------------
    // Software keeps one relocation bit at a time; muxes do not check it
    assign spi_ss_in = spi_relocate ? pin_in.p5[4] : pin_in.p1[4];
    assign spi_mosi_in = spi_relocate ? pin_in.p5[5] : pin_in.p1[5];
    assign spi_miso_in = spi_relocate ? pin_in.p5[6] : pin_in.p1[6];
    assign spi_sck_in = spi_relocate ? pin_in.p5[7] : pin_in.p1[7];
    assign uart1_rx = serial1_relocate ? pin_in.p5[2] : pin_in.p1[2];
    assign t2_in = timer2_relocate ? pin_in.p5[0] : pin_in.p1[0];
    assign t2_ext_in = timer2_relocate ? pin_in.p5[1] : pin_in.p1[1];
    assign counter_array_ext_clock = counter_array_relocate ? pin_in.p6[1] : pin_in.p2[1];
    assign counter_array_in = counter_array_relocate ? pin_in.p6[7:2] : pin_in.p2[7:2];
    assign uart0_rx = (port4_sel == AFR_P4_UART0) ? pin_in.p4[4] : pin_in.p3[0];
    assign t3_ext_in = (port4_sel == AFR_P4_TIMER3) ? pin_in.p4[4] : pin_in.p0[0];
    assign t3_in = (port4_sel == AFR_P4_TIMER3) ? pin_in.p4[5] : pin_in.p0[1];

    // Keypad port select
    assign keypad_in = (keypad_port_sel == 2'h0) ? pin_in.p0 :
        (keypad_port_sel == 2'h1) ? pin_in.p2 :
        (keypad_port_sel == 2'h2) ? pin_in.p5 : pin_in.p6;

    // ------------------------------------------------------------
    // External interrupt sources
    // ------------------------------------------------------------
    logic irq2_pin;
    logic irq3_pin;

    // Own pins move to port 4 pair in interrupt mode
    assign irq2_pin = (port4_sel == AFR_P4_IRQ) ? pin_in.p4[4] : pin_in.p4[3];
    assign irq3_pin = (port4_sel == AFR_P4_IRQ) ? pin_in.p4[5] : pin_in.p4[2];

    // Relocatable sources taken from the pin carrying them now
    assign ext_irq2_in = (irq2_sel == AFR_SRC_OWN) ? irq2_pin :
        (irq2_sel == AFR_SRC_RX) ? uart0_rx :
        (irq2_sel == AFR_SRC_SDA) ? pin_in.p4[1] : spi_ss_in;
    assign ext_irq3_in = (irq3_sel == AFR_SRC_OWN) ? irq3_pin :
        (irq3_sel == AFR_SRC_RX) ? uart1_rx :
        (irq3_sel == AFR_SRC_SDA) ? pin_in.p4[1] : spi_ss_in;

    // ------------------------------------------------------------
    // Output overrides; a zero oe leaves the pin to its port latch
    // ------------------------------------------------------------
    always_comb begin
        alt_out = '0;
        alt_oe = '0;
        // Serial 0 transmit
        if (port4_sel == AFR_P4_UART0) begin
            alt_out.p4[5] = uart0_tx;
            alt_oe.p4[5] = 1'b1;
        end else begin
            alt_out.p3[1] = uart0_tx;
            alt_oe.p3[1] = 1'b1;
        end
        // Timer 3 clock out
        if (port4_sel == AFR_P4_TIMER3) begin
            alt_out.p4[5] = t3_clk_out;
            alt_oe.p4[5] = t3_clk_oe;
        end else begin
            alt_out.p0[1] = t3_clk_out;
            alt_oe.p0[1] = t3_clk_oe;
        end
        // Serial 1 transmit
        if (serial1_relocate) begin
            alt_out.p5[3] = uart1_tx;
            alt_oe.p5[3] = 1'b1;
        end else begin
            alt_out.p1[3] = uart1_tx;
            alt_oe.p1[3] = 1'b1;
        end
        // Timer 2 clock out
        if (timer2_relocate) begin
            alt_out.p5[0] = t2_clk_out;
            alt_oe.p5[0] = t2_clk_oe;
        end else begin
            alt_out.p1[0] = t2_clk_out;
            alt_oe.p1[0] = t2_clk_oe;
        end
        // SPI data and clock
        if (spi_relocate) begin
            alt_out.p5[7:5] = {spi_sck_out, spi_miso_out, spi_mosi_out};
            alt_oe.p5[7:5] = {spi_sck_oe, spi_miso_oe, spi_mosi_oe};
        end else begin
            alt_out.p1[7:5] = {spi_sck_out, spi_miso_out, spi_mosi_out};
            alt_oe.p1[7:5] = {spi_sck_oe, spi_miso_oe, spi_mosi_oe};
        end
        // Counter array compare outputs
        if (counter_array_relocate) begin
            alt_out.p6[7:2] = counter_array_out;
            alt_oe.p6[7:2] = counter_array_oe;
        end else begin
            alt_out.p2[7:2] = counter_array_out;
            alt_oe.p2[7:2] = counter_array_oe;
        end
        // Clock output on pin 6.0
        if (clk_pin_active) begin
            alt_out.p6[0] = clk_out_gen;
            alt_oe.p6[0] = 1'b1;
        end
    end

endmodule // afr_redirect

// ---- rtl/afr_pkg.sv ----
/*
 Package for the alternate function pin redirect block: SFR addresses,
 field positions, reset values, mode codes and the pin bundles.
 Assumes an 8-bit special function register bus from the CPU core.
*/
package afr_pkg;

    // ------------------------------------------------------------
    // Register addresses and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] AFR_ADDR_CTRL0 = 8'hA1;
    localparam logic [7:0] AFR_ADDR_CTRL1 = 8'hA2;
    localparam logic [7:0] AFR_ADDR_CTRL2 = 8'hA3;
    localparam logic [7:0] AFR_RESET_VAL = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AFR_CLK_SEL_HI = 7;
    localparam int AFR_CLK_SEL_LO = 6;
    localparam int AFR_FAST_DRIVE = 5;
    localparam int AFR_P4_SEL_HI = 3;
    localparam int AFR_P4_SEL_LO = 2;
    localparam int AFR_KEY_SEL_HI = 7;
    localparam int AFR_KEY_SEL_LO = 6;
    localparam int AFR_SPI_RELOC = 5;
    localparam int AFR_UART1_RELOC = 4;
    localparam int AFR_T2_RELOC = 3;
    localparam int AFR_CNT_ARRAY_RELOC = 2;
    localparam int AFR_IRQ3_SEL_HI = 7;
    localparam int AFR_IRQ3_SEL_LO = 6;
    localparam int AFR_IRQ2_SEL_HI = 5;
    localparam int AFR_IRQ2_SEL_LO = 4;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AFR_CLK_GPIO = 2'h0,
        AFR_CLK_DIV1 = 2'h1,
        AFR_CLK_DIV2 = 2'h2,
        AFR_CLK_DIV4 = 2'h3
    } afr_clk_fn_t;

    typedef enum logic [1:0] {
        AFR_P4_GPIO = 2'h0,
        AFR_P4_UART0 = 2'h1,
        AFR_P4_IRQ = 2'h2,
        AFR_P4_TIMER3 = 2'h3
    } afr_p4_fn_t;

    typedef enum logic [1:0] {
        AFR_SRC_OWN = 2'h0,
        AFR_SRC_RX = 2'h1,
        AFR_SRC_SDA = 2'h2,
        AFR_SRC_SS = 2'h3
    } afr_irq_src_t;

    typedef enum logic [1:0] {
        AFR_OSC_INTERNAL = 2'h0,
        AFR_OSC_CRYSTAL = 2'h1,
        AFR_OSC_EXTCLK = 2'h2
    } afr_osc_mode_t;

    // ------------------------------------------------------------
    // Pin bundles: one bit per pin of an 8-bit port
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] p0;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
        logic [7:0] p5;
        logic [7:0] p6;
    } afr_ports_t;

    // Clock divider width
    localparam int AFR_DIV_W = 2;

endpackage

// ---- rtl/afr_clk_div.sv ----
/*
 Clock output generator for the clock-capable pin: system clock, /2 or /4.
 Assumes clk is the system clock; the /1 choice is a gated copy of clk.
*/
`timescale 1ns/1ps
module afr_clk_div (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire afr_pkg::afr_clk_fn_t fn,
    // Output
    output logic clk_out
);
    import afr_pkg::*;

    logic [AFR_DIV_W-1:0] cnt;
    logic div_sel;

    // Free running divider counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // Select tap; /1 passes clk itself, the only non-flop path allowed
    assign div_sel = (fn == AFR_CLK_DIV2) ? cnt[0] : cnt[AFR_DIV_W-1];
    assign clk_out = (fn == AFR_CLK_DIV1) ? clk : ((fn == AFR_CLK_GPIO) ? 1'b0 : div_sel);

endmodule // afr_clk_div

// ---- tb/afr_redirect_checker.sv ----
/*
 Checker for the pin redirect block: shadows the control registers and ties the serial rx,
 SPI select, SPI clock when relocated, timer 2 trigger, counter array, interrupt source and clock pin
 signals to their pins. Assumes it is bound to the top.
*/
`timescale 1ns/1ps
module afr_redirect_checker (
    // Clock, reset, register bus
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Pins and routed signals
    input wire afr_pkg::afr_osc_mode_t osc_mode,
    input wire afr_pkg::afr_ports_t pin_in,
    input wire afr_pkg::afr_ports_t alt_out,
    input wire afr_pkg::afr_ports_t alt_oe,
    input wire logic uart0_rx,
    input wire logic uart1_rx,
    input wire logic spi_ss_in,
    input wire logic spi_sck_in,
    input wire logic t2_ext_in,
    input wire logic [5:0] counter_array_in,
    input wire logic [7:0] keypad_in,
    input wire logic ext_irq2_in,
    input wire logic ext_irq3_in,
    input wire logic clk_pin_crystal,
    input wire logic clk_pin_fast_drive
);
    import afr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    logic [7:0] c [4];
    wire logic hit = sfr_addr inside {AFR_ADDR_CTRL0, AFR_ADDR_CTRL1, AFR_ADDR_CTRL2};
    wire logic [7:0] ctl0 = c[1];
    wire logic [7:0] ctl1 = c[2];
    wire logic [7:0] ctl2 = c[3];
    // Own interrupt pins move with the port 4 pair mode
    wire logic own2 = (ctl0[3:2] == 2'h2) ? pin_in.p4[4] : pin_in.p4[3];
    wire logic own3 = (ctl0[3:2] == 2'h2) ? pin_in.p4[5] : pin_in.p4[2];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c <= '{default: 8'h00};
        end else if (sfr_wr && hit) begin
            c[sfr_addr[1:0]] <= sfr_wdata;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_map;
        hit ? (sfr_hit && sfr_rdata == c[sfr_addr[1:0]]) : (!sfr_hit && sfr_rdata == 8'h00);
    endproperty
    a_map: assert property (p_map) else $error("register map");
    property p_spi; ctl1[5] |-> spi_ss_in == pin_in.p5[4] && spi_sck_in == pin_in.p5[7] && alt_oe.p1[7:4] == 4'h0; endproperty
    a_spi: assert property (p_spi) else $error("spi moved");
    property p_spi_def; !ctl1[5] |-> spi_ss_in == pin_in.p1[4] && alt_oe.p5[7:4] == 4'h0; endproperty
    a_spi_def: assert property (p_spi_def) else $error("spi default");
    property p_u1; uart1_rx == (ctl1[4] ? pin_in.p5[2] : pin_in.p1[2]); endproperty
    a_u1: assert property (p_u1) else $error("serial1 rx");
    property p_t2; t2_ext_in == (ctl1[3] ? pin_in.p5[1] : pin_in.p1[1]); endproperty
    a_t2: assert property (p_t2) else $error("timer2 trigger");
    property p_carr; counter_array_in == (ctl1[2] ? pin_in.p6[7:2] : pin_in.p2[7:2]); endproperty
    a_carr: assert property (p_carr) else $error("counter array");
    property p_u0; uart0_rx == (ctl0[3:2] == 2'h1 ? pin_in.p4[4] : pin_in.p3[0]); endproperty
    a_u0: assert property (p_u0) else $error("serial0 rx");
    property p_irq2; ext_irq2_in == (ctl2[5] ? (ctl2[4] ? spi_ss_in : pin_in.p4[1]) : (ctl2[4] ? uart0_rx : own2)); endproperty
    a_irq2: assert property (p_irq2) else $error("irq2 source");
    property p_irq3; ext_irq3_in == (ctl2[7] ? (ctl2[6] ? spi_ss_in : pin_in.p4[1]) : (ctl2[6] ? uart1_rx : own3)); endproperty
    a_irq3: assert property (p_irq3) else $error("irq3 source");
    property p_osc; clk_pin_crystal == (osc_mode != AFR_OSC_INTERNAL) && clk_pin_fast_drive == ctl0[5]; endproperty
    a_osc: assert property (p_osc) else $error("clock pin owner");
    property p_ckoff; (osc_mode != AFR_OSC_INTERNAL || ctl0[7:6] == 2'h0) |-> !alt_oe.p6[0]; endproperty
    a_ckoff: assert property (p_ckoff) else $error("clock pin driven");
    property p_div2;
        (osc_mode == AFR_OSC_INTERNAL && ctl0[7:6] == 2'h2) [*2] |-> alt_oe.p6[0] && alt_out.p6[0] != $past(alt_out.p6[0]);
    endproperty
    a_div2: assert property (p_div2) else $error("clock half rate");
    c_spi: cover property (ctl1[5]);
    c_irq: cover property (ctl2[7:6] == 2'h3 && ctl2[5:4] == 2'h3);
    c_div4: cover property (osc_mode == AFR_OSC_INTERNAL && ctl0[7:6] == 2'h3);
endmodule // afr_redirect_checker

// ---- tb/afr_periph_model.sv ----
/*
 Far side of the pin redirect block: pin levels and peripheral outputs.
 Assumes the bench slices the drive bundle onto the peripheral ports.
*/
`timescale 1ns/1ps
module afr_periph_model (
    // Clock
    input wire logic clk,
    // Pins and peripheral drive
    output afr_pkg::afr_ports_t pin_in,
    output logic [23:0] periph_drv
);
    import afr_pkg::*;
    logic [7:0] cnt = 8'h00;
    // Levels move each cycle so a stale mux path cannot match by luck
    always @(negedge clk) cnt <= cnt + 8'h01;
    // Ports differ by multiplier; drive type of the clock pin is the port's
    assign pin_in = {cnt, cnt * 8'h03, cnt * 8'h05, cnt * 8'h07, cnt * 8'h0B, cnt * 8'h0D, cnt * 8'h11};
    assign periph_drv = {cnt * 8'h13, ~cnt, cnt};
endmodule // afr_periph_model

// ---- tb/afr_redirect_tb.sv ----
/*
 Bench for the pin redirect block: registers, relocation, interrupt
 sources and clock pin. Assumes the far-side model and bound checker.
*/
`timescale 1ns/1ps
module afr_redirect_tb;
    import afr_pkg::*;
    logic clk, nrst, sfr_wr, t3_ext_in, ext_irq2_in, clk_pin_crystal, clk_pin_fast_drive;
    logic t3_in, t2_in, spi_mosi_in, spi_miso_in, counter_array_ext_clock;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, keypad_in;
    logic [5:0] counter_array_in;
    logic [23:0] drv;
    afr_osc_mode_t osc_mode;
    afr_ports_t pin_in, alt_out, alt_oe;
    int miscompares = 0;
    int samples_checked = 0;

    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    afr_periph_model u_far (.clk, .pin_in, .periph_drv(drv));
    afr_redirect u_dut (.clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_hit(), .osc_mode, .pin_in,
        .uart0_tx(drv[0]), .uart1_tx(drv[1]), .spi_mosi_out(drv[2]), .spi_mosi_oe(drv[3]), .spi_miso_out(drv[4]),
        .spi_miso_oe(drv[5]), .spi_sck_out(drv[6]), .spi_sck_oe(drv[7]), .t2_clk_out(drv[8]), .t2_clk_oe(drv[9]),
        .t3_clk_out(drv[10]), .t3_clk_oe(drv[11]), .counter_array_out(drv[17:12]), .counter_array_oe(drv[23:18]),
        .uart0_rx(), .uart1_rx(), .spi_ss_in(), .spi_mosi_in, .spi_miso_in, .spi_sck_in(), .t2_in, .t2_ext_in(),
        .t3_in, .t3_ext_in, .counter_array_ext_clock, .counter_array_in, .keypad_in, .ext_irq2_in, .ext_irq3_in(),
        .alt_out, .alt_oe, .clk_pin_crystal, .clk_pin_fast_drive);

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask

    // One write, then an idle cycle so the strobe never re-rises in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        #1;
    endtask

    task automatic rd_all(input logic [7:0] base);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            sfr_addr = 8'hA0 + 8'(i);
            #1 chk("rd", sfr_rdata, (i % 4 != 0 && base != 0) ? base ^ 8'(i) : 8'h00);
        end
    endtask

    task automatic t_regs;
        rd_all(8'h00);
        for (int i = 0; i < 5; i++) wr(8'hA0 + 8'(i), 8'hC3 ^ 8'(i));
        rd_all(8'hC3);
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        rd_all(8'h00);
    endtask

    task automatic t_reloc;
        logic [7:0] e;
        wr(8'hA3, 8'h70);
        for (int b = 2; b < 6; b++) begin
            wr(8'hA2, 8'h01 << b); // one relocation bit at a time
            chk("carr", 8'(counter_array_in), 8'(b == 2 ? pin_in.p6[7:2] : pin_in.p2[7:2]));
            if (b == 2) chk("p2oe", 8'(alt_oe.p2[7:1]), 8'h00);
            chk("p6o", 8'(alt_out.p6[7:2]), 8'(b == 2 ? drv[17:12] : 6'h00));
            chk("p6e", 8'(alt_oe.p6[7:2]), 8'(b == 2 ? drv[23:18] : 6'h00));
            // Inputs that only the bench watches: SPI data, timer 2 input, external count
            e = {4'h0, (b == 5) ? pin_in.p5[6:5] : pin_in.p1[6:5], (b == 3) ? pin_in.p5[0] : pin_in.p1[0],
                (b == 2) ? pin_in.p6[1] : pin_in.p2[1]};
            chk("ins", {4'h0, spi_miso_in, spi_mosi_in, t2_in, counter_array_ext_clock}, e);
            // Relocated timer 2, serial 1 and SPI outputs land on port 5, nothing else there
            e = (b == 3) ? {7'h00, drv[8]} : (b == 4) ? {4'h0, drv[1], 3'h0} :
                (b == 5) ? {drv[6], drv[4], drv[2], 5'h00} : 8'h00;
            chk("p5o", alt_out.p5, e);
            e = (b == 3) ? {7'h00, drv[9]} : (b == 4) ? 8'h08 : (b == 5) ? {drv[7], drv[5], drv[3], 5'h00} : 8'h00;
            chk("p5e", alt_oe.p5, e);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'hA2, 8'(k) << 6);
            chk("key", keypad_in, k == 0 ? pin_in.p0 : k == 1 ? pin_in.p2 : k == 2 ? pin_in.p5 : pin_in.p6);
        end
    endtask

    task automatic t_irq;
        logic [7:0] e;
        logic [7:0] g;
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 4; s++) begin
                wr(8'hA1, 8'(m) << 2);
                wr(8'hA3, 8'(s * 8'h50));
                if (s == 2) chk("irq2", 8'(ext_irq2_in), 8'(pin_in.p4[1]));
                if (s == 0) chk("irq2", 8'(ext_irq2_in), 8'(m == 2 ? pin_in.p4[4] : pin_in.p4[3]));
                chk("t3x", 8'(t3_ext_in), 8'(m == 3 ? pin_in.p4[4] : pin_in.p0[0]));
                chk("t3i", 8'(t3_in), 8'(m == 3 ? pin_in.p4[5] : pin_in.p0[1]));
                // Serial 0 and timer 3 outputs: home pins p3.1/p0.1 or the shared p4.5
                e = {2'h0, (m == 1) ? 2'h0 : {drv[0], 1'b1}, (m == 3) ? 2'h0 : {drv[10], drv[11]},
                    (m == 1) ? {drv[0], 1'b1} : (m == 3) ? {drv[10], drv[11]} : 2'h0};
                g = {2'h0, alt_out.p3[1], alt_oe.p3[1], alt_out.p0[1], alt_oe.p0[1], alt_out.p4[5], alt_oe.p4[5]};
                chk("tx", g, e);
            end
        end
    endtask

    task automatic t_clk;
        logic l;
        int n;
        for (int o = 0; o < 3; o++) begin
            @(negedge clk);
            osc_mode = afr_osc_mode_t'(o);
            for (int f = 0; f < 4; f++) begin
                wr(8'hA1, {2'(f), 6'h20});
                chk("pin", 8'({alt_oe.p6[0], clk_pin_crystal, clk_pin_fast_drive}),
                    8'({o == 0 && f != 0, o != 0, 1'b1}));
                n = 0;
                @(clk) #2 l = alt_out.p6[0];
                repeat (32) begin
                    @(clk) #2 n += int'(alt_out.p6[0] !== l);
                    l = alt_out.p6[0];
                end
                if (o == 0 && f != 0) chk("div", 8'(n), 8'(64 >> f));
            end
        end
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        sfr_wr = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        osc_mode = AFR_OSC_INTERNAL;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        t_regs;
        t_reloc;
        t_irq;
        t_clk;
        end_sim;
    end

    // Watchdog: the tests need well under 10 us
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
endmodule // afr_redirect_tb

bind afr_redirect afr_redirect_checker u_chk (.clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_hit,
    .osc_mode, .pin_in, .alt_out, .alt_oe, .uart0_rx, .uart1_rx, .spi_ss_in, .spi_sck_in, .t2_ext_in, .counter_array_in,
    .keypad_in, .ext_irq2_in, .ext_irq3_in, .clk_pin_crystal, .clk_pin_fast_drive);
